// ==== design/flash_bridge_map.vh ====
`ifndef FLASH_BRIDGE_MAP_VH
`define FLASH_BRIDGE_MAP_VH

// host command codes
`define CMD_READ_ARRAY 8'hff
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_READ_QUERY 8'h98
`define CMD_READ_ID 8'h90
`define CMD_ERASE_SETUP 8'h20
`define CMD_SINGLE_WRITE 8'h40
`define CMD_MULTI_WRITE 8'he8
`define CMD_LOCK_SETUP 8'h60
`define CMD_CONFIRM 8'hd0
`define CMD_LOCK_CONFIRM 8'h01

// status value layout
`define STATUS_RESET 8'h80
`define STATUS_READY_BIT 7
`define STATUS_ERR_LO 4

// flash width codes
`define WIDTH_BYTE 2'h0
`define WIDTH_HALF 2'h1
`define WIDTH_WORD 2'h2

// bus sizes
`define ADDR_W 18
`define DATA_W 32
`define CMD_W 52
`define ADDR_SIZE_DEFAULT 18
`define ADDR_FULL_MASK 18'h3ffff

// write page geometry: 128-byte page, element count up to 7 bits
`define PAGE_OFFSET_BITS 7
`define PAGE_OFFSET_MASK 18'h0007f
`define MW_COUNT_BITS 7

`endif

// ==== design/cmd_buffer.v ====
`timescale 1ns/1ps
`include "flash_bridge_map.vh"

module cmd_buffer #(
  parameter WIDTH = `CMD_W
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] head;
  reg [WIDTH-1:0] tail;
  reg head_valid;
  reg tail_valid;
  wire push;
  wire pop;

  // the head entry drives the output straight from flops
  assign in_ready = ~tail_valid;
  assign out_valid = head_valid;
  assign out_data = head;
  assign push = in_valid & in_ready;
  assign pop = head_valid & out_ready;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head <= {WIDTH{1'b0}};
      tail <= {WIDTH{1'b0}};
      head_valid <= 1'b0;
      tail_valid <= 1'b0;
    end else if (pop && push) begin
      head <= in_data;
    end else if (pop) begin
      head <= tail;
      head_valid <= tail_valid;
      tail_valid <= 1'b0;
    end else if (push && !head_valid) begin
      head <= in_data;
      head_valid <= 1'b1;
    end else if (push) begin
      tail <= in_data;
      tail_valid <= 1'b1;
    end
  end

endmodule

// ==== design/parallel_flash_host_bridge.v ====
`timescale 1ns/1ps
`include "flash_bridge_map.vh"

// Overview of operation
// - address width parameter 6 to 18
// - width selects choose 8, 16, 32 bits
// - wider modes drop low host address bits
// - upper write lanes ignored in narrow modes
// - output enable low when select and read
// - writes only with select and write enable
// - write executes edge after its sample
// - reset gives read array, status 80h, tristate
// - busy shown for writes, never reads
// - one clock, host inputs synchronised first
// - pulse read and buffer write requests
// - program commits buffer, protect bit optional
// - erase request clears addressed page
// - unprotect request copies page to buffer
// - discard request drops page buffer
// - spare page and page status selects
// - drive 18-bit flash byte address
// - drive two-bit flash width code
// - ignore host commands while busy
// - abort multi-write without exact confirm
module parallel_flash_host_bridge #(
  parameter ADDR_SIZE = `ADDR_SIZE_DEFAULT
) (
  input wire core_clk,
  input wire reset_n,
  input wire chip_sel_n,
  input wire out_en_n,
  input wire write_en_n,
  input wire wide_sel_n,
  input wire byte_sel_n,
  input wire [17:0] host_addr,
  input wire [31:0] host_wdata,
  output reg [31:0] host_rdata,
  output wire host_rdata_oe_n,
  output wire busy_out_n,
  input wire mem_busy,
  input wire [31:0] mem_rdata,
  input wire [1:0] mem_last_status,
  output reg mem_read_req,
  output reg mem_buf_write_req,
  output reg mem_program_req,
  output reg mem_erase_req,
  output reg mem_set_protect,
  output reg mem_unprotect_req,
  output reg mem_discard_req,
  output reg mem_spare_sel,
  output reg mem_page_stat_sel,
  output reg [17:0] mem_addr,
  output reg [31:0] mem_wdata,
  output reg [1:0] mem_width_code
);

  // sequencer states
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_SETTLE = 3'b010;
  localparam [2:0] S_WAIT = 3'b100;
  // command phases
  localparam [6:0] P_NONE = 7'b0000001;
  localparam [6:0] P_ERASE = 7'b0000010;
  localparam [6:0] P_SINGLE = 7'b0000100;
  localparam [6:0] P_MW_COUNT = 7'b0001000;
  localparam [6:0] P_MW_DATA = 7'b0010000;
  localparam [6:0] P_MW_CONFIRM = 7'b0100000;
  localparam [6:0] P_LOCK = 7'b1000000;
  // read modes
  localparam [3:0] M_ARRAY = 4'b0001;
  localparam [3:0] M_STATUS = 4'b0010;
  localparam [3:0] M_QUERY = 4'b0100;
  localparam [3:0] M_ID = 4'b1000;

  // sizes outside 6..18 are clamped so the mask stays meaningful
  localparam integer SIZE_USED = (ADDR_SIZE < 6) ? 6 : ((ADDR_SIZE > 18) ? 18 : ADDR_SIZE);
  localparam [17:0] SIZE_MASK = `ADDR_FULL_MASK >> (18 - SIZE_USED);

  function [1:0] width_of;
    input wide_n;
    input byte_n;
    begin
      if (!byte_n) begin
        width_of = `WIDTH_BYTE;
      end else if (!wide_n) begin
        width_of = `WIDTH_HALF;
      end else begin
        width_of = `WIDTH_WORD;
      end
    end
  endfunction

  function [17:0] byte_addr;
    input [17:0] a;
    input [1:0] w;
    begin
      case (w)
        `WIDTH_BYTE: byte_addr = a & SIZE_MASK;
        `WIDTH_HALF: byte_addr = {a[17:1], 1'b0} & SIZE_MASK;
        default: byte_addr = {a[17:2], 2'b00} & SIZE_MASK;
      endcase
    end
  endfunction

  function [31:0] lane_data;
    input [31:0] d;
    input [1:0] w;
    begin
      case (w)
        `WIDTH_BYTE: lane_data = {24'h000000, d[7:0]};
        `WIDTH_HALF: lane_data = {16'h0000, d[15:0]};
        default: lane_data = d;
      endcase
    end
  endfunction

  reg [1:0] rst_pipe;
  wire rst_n;
  reg [54:0] sync1;
  reg [54:0] sync2;
  wire cs_s;
  wire oe_s;
  wire we_s;
  wire [1:0] width_s;
  wire [17:0] addr_s;
  wire [31:0] data_s;
  reg wr_prev;
  wire wr_active;
  wire wr_start;
  wire buf_in_ready;
  wire buf_in_valid;
  wire buf_valid;
  wire buf_pop;
  wire [51:0] buf_data;
  wire [17:0] cmd_addr;
  wire [31:0] cmd_data;
  wire [1:0] cmd_width;
  wire [7:0] cmd_code;
  wire rd_active;
  wire [17:0] rd_byte_addr;
  wire ready_bit;
  wire [7:0] status_value;
  reg [2:0] state;
  reg [6:0] phase;
  reg [3:0] mode;
  reg writing;
  reg reading;
  reg then_prog;
  reg [1:0] err_bits;
  reg [17:0] page_base;
  reg [6:0] mw_count;
  reg rd_ok;
  reg [17:0] rd_addr;

  // reset leaves through two flops so release is clean on core_clk
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // whole host bus sampled twice so strobes and data stay aligned
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= {55{1'b1}};
      sync2 <= {55{1'b1}};
    end else begin
      sync1 <= {chip_sel_n, out_en_n, write_en_n, wide_sel_n, byte_sel_n, host_addr, host_wdata};
      sync2 <= sync1;
    end
  end

  assign cs_s = ~sync2[54];
  assign oe_s = ~sync2[53];
  assign we_s = ~sync2[52];
  assign width_s = width_of(sync2[51], sync2[50]);
  assign addr_s = sync2[49:32];
  assign data_s = sync2[31:0];

  // one command per write strobe; taken when the later of select and write enable goes active
  assign wr_active = cs_s & we_s;
  assign wr_start = wr_active & ~wr_prev;

  // writes arriving while busy or with the buffer full are dropped
  assign buf_in_valid = wr_start & ~writing;

  cmd_buffer #(
    .WIDTH(`CMD_W)
  ) u_cmd_buffer (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data({width_s, byte_addr(addr_s, width_s), lane_data(data_s, width_s)}),
    .out_valid(buf_valid),
    .out_ready(buf_pop),
    .out_data(buf_data)
  );

  assign cmd_width = buf_data[51:50];
  assign cmd_addr = buf_data[49:32];
  assign cmd_data = buf_data[31:0];
  assign cmd_code = buf_data[7:0];
  assign buf_pop = (state == S_IDLE) & ~writing;

  assign rd_active = cs_s & oe_s & ~we_s;
  assign rd_byte_addr = byte_addr(addr_s, width_s);

  assign ready_bit = ~mem_busy & ~writing;
  assign status_value = {ready_bit, 1'b0, err_bits, 4'h0};

  // tristate whenever not selected for read, and throughout reset
  assign host_rdata_oe_n = chip_sel_n | out_en_n | ~rst_n;
  assign busy_out_n = ~writing;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev <= 1'b0;
      state <= S_IDLE;
      phase <= P_NONE;
      mode <= M_ARRAY;
      writing <= 1'b0;
      reading <= 1'b0;
      then_prog <= 1'b0;
      err_bits <= 2'b00;
      page_base <= 18'h00000;
      mw_count <= 7'h00;
      rd_ok <= 1'b0;
      rd_addr <= 18'h00000;
      host_rdata <= {24'h000000, `STATUS_RESET};
      mem_read_req <= 1'b0;
      mem_buf_write_req <= 1'b0;
      mem_program_req <= 1'b0;
      mem_erase_req <= 1'b0;
      mem_set_protect <= 1'b0;
      mem_unprotect_req <= 1'b0;
      mem_discard_req <= 1'b0;
      mem_spare_sel <= 1'b0;
      mem_page_stat_sel <= 1'b0;
      mem_addr <= 18'h00000;
      mem_wdata <= 32'h00000000;
      mem_width_code <= `WIDTH_BYTE;
    end else begin
      wr_prev <= wr_active;
      mem_read_req <= 1'b0;
      mem_buf_write_req <= 1'b0;
      mem_program_req <= 1'b0;
      mem_erase_req <= 1'b0;
      mem_unprotect_req <= 1'b0;
      mem_discard_req <= 1'b0;
      case (state)
        S_IDLE: begin
          if (mode == M_STATUS) begin
            host_rdata <= {24'h000000, status_value};
          end
          if (then_prog) begin
            // single write: buffer loaded, now commit it
            then_prog <= 1'b0;
            mem_addr <= page_base;
            mem_program_req <= 1'b1;
            writing <= 1'b1;
            state <= S_SETTLE;
          end else if (buf_valid && !writing) begin
            mem_width_code <= cmd_width;
            mem_wdata <= cmd_data;
            rd_ok <= 1'b0;
            case (phase)
              P_NONE: begin
                page_base <= cmd_addr & ~`PAGE_OFFSET_MASK;
                case (cmd_code)
                  `CMD_READ_ARRAY: mode <= M_ARRAY;
                  `CMD_READ_STATUS: mode <= M_STATUS;
                  `CMD_CLEAR_STATUS: err_bits <= 2'b00;
                  `CMD_READ_QUERY: mode <= M_QUERY;
                  `CMD_READ_ID: mode <= M_ID;
                  `CMD_ERASE_SETUP: phase <= P_ERASE;
                  `CMD_SINGLE_WRITE: phase <= P_SINGLE;
                  `CMD_MULTI_WRITE: phase <= P_MW_COUNT;
                  `CMD_LOCK_SETUP: phase <= P_LOCK;
                  default: mode <= mode;
                endcase
              end
              P_ERASE: begin
                phase <= P_NONE;
                mode <= M_STATUS;
                if (cmd_code == `CMD_CONFIRM) begin
                  mem_addr <= page_base;
                  mem_erase_req <= 1'b1;
                  writing <= 1'b1;
                  state <= S_SETTLE;
                end
              end
              P_SINGLE: begin
                phase <= P_NONE;
                mode <= M_STATUS;
                page_base <= cmd_addr & ~`PAGE_OFFSET_MASK;
                mem_addr <= cmd_addr;
                mem_buf_write_req <= 1'b1;
                then_prog <= 1'b1;
                writing <= 1'b1;
                state <= S_SETTLE;
              end
              P_MW_COUNT: begin
                // fresh page buffer before the data words arrive
                mw_count <= cmd_data[6:0];
                phase <= P_MW_DATA;
                mode <= M_STATUS;
                mem_addr <= page_base;
                mem_discard_req <= 1'b1;
                writing <= 1'b1;
                state <= S_SETTLE;
              end
              P_MW_DATA: begin
                // page bits ignored: addresses wrap inside the page latched from the multi-write setup address
                mem_addr <= page_base | (cmd_addr & `PAGE_OFFSET_MASK);
                mem_buf_write_req <= 1'b1;
                writing <= 1'b1;
                state <= S_SETTLE;
                if (mw_count == 7'h00) begin
                  phase <= P_MW_CONFIRM;
                end else begin
                  mw_count <= mw_count - 7'h01;
                end
              end
              P_MW_CONFIRM: begin
                phase <= P_NONE;
                mem_addr <= page_base;
                writing <= 1'b1;
                state <= S_SETTLE;
                if (cmd_code == `CMD_CONFIRM) begin
                  mem_program_req <= 1'b1;
                end else begin
                  mem_discard_req <= 1'b1;
                end
              end
              P_LOCK: begin
                phase <= P_NONE;
                mode <= M_STATUS;
                mem_addr <= cmd_addr & ~`PAGE_OFFSET_MASK;
                if (cmd_code == `CMD_LOCK_CONFIRM) begin
                  mem_set_protect <= 1'b1;
                  mem_program_req <= 1'b1;
                  writing <= 1'b1;
                  state <= S_SETTLE;
                end else if (cmd_code == `CMD_CONFIRM) begin
                  mem_unprotect_req <= 1'b1;
                  writing <= 1'b1;
                  state <= S_SETTLE;
                end
              end
              default: phase <= P_NONE;
            endcase
          end else if (rd_active && mode != M_STATUS && !(rd_ok && rd_addr == rd_byte_addr)) begin
            // reads never raise busy; the host waits out the latency itself
            rd_addr <= rd_byte_addr;
            mem_addr <= rd_byte_addr;
            mem_width_code <= width_s;
            mem_spare_sel <= (mode == M_QUERY);
            mem_page_stat_sel <= (mode == M_ID);
            mem_read_req <= 1'b1;
            reading <= 1'b1;
            state <= S_SETTLE;
          end
        end
        S_SETTLE: begin
          // one cycle for the flash to raise its busy flag
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (!mem_busy) begin
            state <= S_IDLE;
            if (reading) begin
              host_rdata <= lane_data(mem_rdata, mem_width_code);
              rd_ok <= 1'b1;
              reading <= 1'b0;
              mem_spare_sel <= 1'b0;
              mem_page_stat_sel <= 1'b0;
            end else begin
              writing <= then_prog;
              mem_set_protect <= 1'b0;
              err_bits <= err_bits | mem_last_status;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

// ==== verif/flash_macro_model.sv ====
`timescale 1ns/1ps
module flash_macro_model #(
  parameter int LONG = 40
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic rd,
  input wire logic bw,
  input wire logic pg,
  input wire logic er,
  input wire logic un,
  input wire logic dc,
  input wire logic [17:0] addr,
  output logic mem_busy,
  output logic [31:0] mem_rdata,
  output logic [1:0] mem_last_status
);
  int left;
  logic [31:0] pat;
  assign mem_last_status = 2'h0;
  // word hidden while busy so a stale sample never matches
  assign mem_rdata = mem_busy ? ~pat : pat;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      left <= 0;
      mem_busy <= 1'b0;
      pat <= 32'h0;
    end else if (rd | bw | dc) begin
      left <= 2;
      mem_busy <= 1'b1;
      if (rd) pat <= {addr[13:0], addr};
    end else if (pg | er | un) begin
      left <= LONG;
      mem_busy <= 1'b1;
    end else if (left > 1) begin
      left <= left - 1;
    end else begin
      left <= 0;
      mem_busy <= 1'b0;
    end
  end
endmodule

// ==== verif/parallel_flash_host_bridge_asserts.sv ====
`timescale 1ns/1ps
module parallel_flash_host_bridge_asserts #(
  parameter ADDR_SIZE = 18
) (
  input wire core_clk,
  input wire reset_n,
  input wire chip_sel_n,
  input wire out_en_n,
  input wire wide_sel_n,
  input wire byte_sel_n,
  input wire [31:0] host_rdata,
  input wire host_rdata_oe_n,
  input wire busy_out_n,
  input wire mem_busy,
  input wire mem_read_req,
  input wire mem_buf_write_req,
  input wire mem_program_req,
  input wire mem_erase_req,
  input wire mem_unprotect_req,
  input wire [17:0] mem_addr,
  input wire [1:0] mem_width_code
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [1:0] up;
  logic [1:0] wexp;
  assign wexp = !byte_sel_n ? 2'h0 : (!wide_sel_n ? 2'h1 : 2'h2);
  // internal reset copy lags the pin, so drive checks wait for it
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  a_oe_idle: assert property (chip_sel_n || out_en_n |-> host_rdata_oe_n)
    else $error("data enable active without select and read");
  a_oe_drive: assert property (up == 2'h3 && !chip_sel_n && !out_en_n |-> !host_rdata_oe_n)
    else $error("data enable inactive during select and read");
  a_reset_state: assert property ($rose(reset_n) |->
    host_rdata == 32'h00000080 && busy_out_n && host_rdata_oe_n)
    else $error("reset state wrong");
  a_pulse_single: assert property (mem_read_req || mem_buf_write_req |=>
    !mem_read_req && !mem_buf_write_req)
    else $error("request pulse longer than one cycle");
  a_read_not_busy: assert property (mem_read_req |-> busy_out_n ##1 busy_out_n [*3])
    else $error("busy shown for a read");
  a_write_busy: assert property (mem_erase_req || mem_program_req |-> !busy_out_n)
    else $error("busy missing for write-type operation");
  // a single write chains its buffer load straight into the program step
  a_ready_return: assert property ($fell(mem_busy) && !busy_out_n |->
    ##[1:3] (busy_out_n || mem_program_req))
    else $error("busy held after flash finished");
  a_idle_quiet: assert property (chip_sel_n [*5] |->
    !mem_erase_req && !mem_unprotect_req && !mem_read_req)
    else $error("request without host select");
  a_width_code: assert property (mem_buf_write_req || mem_read_req |-> mem_width_code == wexp)
    else $error("width code mismatch");
  a_addr_align: assert property (mem_read_req && byte_sel_n |->
    (wide_sel_n ? mem_addr[1:0] == 2'h0 : !mem_addr[0]))
    else $error("low address bits not dropped");
endmodule
bind parallel_flash_host_bridge parallel_flash_host_bridge_asserts #(.ADDR_SIZE(ADDR_SIZE)) chk (
  .core_clk(core_clk), .reset_n(reset_n), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
  .wide_sel_n(wide_sel_n), .byte_sel_n(byte_sel_n), .host_rdata(host_rdata),
  .host_rdata_oe_n(host_rdata_oe_n), .busy_out_n(busy_out_n), .mem_busy(mem_busy),
  .mem_read_req(mem_read_req), .mem_buf_write_req(mem_buf_write_req),
  .mem_program_req(mem_program_req), .mem_erase_req(mem_erase_req),
  .mem_unprotect_req(mem_unprotect_req), .mem_addr(mem_addr), .mem_width_code(mem_width_code));

// ==== verif/parallel_flash_host_bridge_tb_top.sv ====
`timescale 1ns/1ps
module parallel_flash_host_bridge_tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic chip_sel_n = 1'b1;
  logic out_en_n = 1'b1;
  logic write_en_n = 1'b1;
  logic wide_sel_n = 1'b1;
  logic byte_sel_n = 1'b0;
  logic [17:0] host_addr = 18'h0;
  logic [31:0] host_wdata = 32'h0;
  wire [31:0] host_rdata, mem_rdata, mem_wdata;
  wire host_rdata_oe_n, busy_out_n, mem_busy, rd, bw, pg, er, prot, un, dc, sp, ps;
  wire [1:0] mem_last_status, mem_width_code;
  wire [17:0] mem_addr;
  int bad_count = 0;
  int total_checks = 0;
  int cyc, t0, er_cyc, n_rd, n_bw, n_pg, n_er, n_un, n_dc, k;
  logic seen_sp, seen_ps, seen_prot;
  logic [31:0] d;
  logic [17:0] ea;
  always #10 core_clk = ~core_clk;
  parallel_flash_host_bridge #(.ADDR_SIZE(18)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .write_en_n(write_en_n), .wide_sel_n(wide_sel_n), .byte_sel_n(byte_sel_n),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rdata_oe_n(host_rdata_oe_n), .busy_out_n(busy_out_n), .mem_busy(mem_busy),
    .mem_rdata(mem_rdata), .mem_last_status(mem_last_status), .mem_read_req(rd),
    .mem_buf_write_req(bw), .mem_program_req(pg), .mem_erase_req(er), .mem_set_protect(prot),
    .mem_unprotect_req(un), .mem_discard_req(dc), .mem_spare_sel(sp),
    .mem_page_stat_sel(ps), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_width_code(mem_width_code));
  flash_macro_model #(.LONG(40)) flash (
    .core_clk(core_clk), .reset_n(reset_n), .rd(rd), .bw(bw), .pg(pg), .er(er), .un(un),
    .dc(dc), .addr(mem_addr), .mem_busy(mem_busy), .mem_rdata(mem_rdata),
    .mem_last_status(mem_last_status));
  always @(posedge core_clk) begin
    cyc++;
    if (rd) begin
      n_rd++;
      seen_sp = sp;
      seen_ps = ps;
    end
    if (pg) begin
      n_pg++;
      seen_prot = prot;
    end
    if (er) begin
      n_er++;
      er_cyc = cyc;
    end
    n_bw += bw;
    n_un += un;
    n_dc += dc;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 300 && busy_out_n !== 1'b1; i++) @(negedge core_clk);
  endtask
  // strobes held past the two synchroniser stages, then dropped together
  task automatic hw(input logic [17:0] a, input logic [31:0] v);
    @(negedge core_clk);
    t0 = cyc + 1;
    chip_sel_n = 1'b0;
    write_en_n = 1'b0;
    host_addr = a;
    host_wdata = v;
    repeat (3) @(negedge core_clk);
    chip_sel_n = 1'b1;
    write_en_n = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic hr(input logic [17:0] a, output logic [31:0] v);
    @(negedge core_clk);
    chip_sel_n = 1'b0;
    host_addr = a;
    @(negedge core_clk);
    chk(host_rdata_oe_n, 32'h1);
    out_en_n = 1'b0;
    repeat (14) @(negedge core_clk);
    chk(host_rdata_oe_n, 32'h0);
    v = host_rdata;
    chip_sel_n = 1'b1;
    out_en_n = 1'b1;
    @(negedge core_clk);
  endtask
  task automatic t_modes();
    for (int i = 0; i < 3; i++) begin
      byte_sel_n = (i != 0);
      wide_sel_n = (i != 1);
      ea = 18'h00155 + 18'(i * 16);
      ea = ea & ~18'(i == 0 ? 0 : (i == 1 ? 1 : 3));
      hr(18'h00155 + 18'(i * 16), d);
      chk(d, {ea[13:0], ea} & (i == 0 ? 32'hff : (i == 1 ? 32'hffff : 32'hffffffff)));
      chk(mem_addr, ea);
      chk(mem_width_code, i);
    end
    byte_sel_n = 1'b0;
    wide_sel_n = 1'b1;
  endtask
  task automatic t_erase();
    k = n_er;
    hw(18'h00280, 32'h20);
    hw(18'h00280, 32'hd0);
    chk(er_cyc, t0 + 4);
    chk(mem_addr, 18'h00280);
    chk(busy_out_n, 32'h0);
    hw(18'h00300, 32'h20);
    hw(18'h00300, 32'hd0);
    wait_ready();
    chk(busy_out_n, 32'h1);
    chk(n_er, k + 1);
  endtask
  task automatic t_multi(input int cnt, input logic [7:0] last);
    int p0, b0, c0;
    p0 = n_pg;
    b0 = n_bw;
    c0 = n_dc;
    hw(18'h00300, 32'he8);
    wait_ready();
    hw(18'h00300, 32'(cnt - 1));
    for (int j = 0; j < cnt; j++) begin
      wait_ready();
      hw(18'h00300 + 18'(j), 32'hdeadbe10 + 32'(j));
    end
    chk(mem_wdata[7:0], 8'h10 + 8'(cnt - 1));
    wait_ready();
    hw(18'h00300, {24'h0, last});
    wait_ready();
    chk(n_bw, b0 + cnt);
    chk(n_pg, p0 + (last == 8'hd0));
    chk(n_dc, c0 + 1 + (last != 8'hd0));
  endtask
  task automatic t_single();
    int p0, b0;
    p0 = n_pg;
    b0 = n_bw;
    hw(18'h0, 32'h40);
    hw(18'h00391, 32'h1234565a);
    chk(mem_addr, 18'h00391);
    chk(mem_wdata, 32'h5a);
    wait_ready();
    chk(n_bw, b0 + 1);
    chk(n_pg, p0 + 1);
    chk(mem_addr, 18'h00380);
    hw(18'h0, 32'hff);
    hr(18'h00022, d);
    chk(d, 32'h22);
  endtask
  // status mode first, so a read after reset proves the return to array mode
  task automatic t_reset();
    hw(18'h0, 32'h70);
    wait_ready();
    @(negedge core_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    chk(host_rdata, 32'h80);
    chk(host_rdata_oe_n, 32'h1);
    repeat (3) @(negedge core_clk);
    hr(18'h00010, d);
    chk(d, 32'h10);
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    chk(host_rdata, 32'h80);
    chk(busy_out_n, 32'h1);
    repeat (4) @(negedge core_clk);
    t_modes();
    t_erase();
    k = n_dc;
    t_multi(3, 8'hd0);
    chk(n_dc, k + 1);
    t_multi(2, 8'h70);
    k = n_pg;
    hw(18'h0, 32'h60);
    hw(18'h00380, 32'h01);
    wait_ready();
    chk({seen_prot, n_pg[30:0]}, {1'b1, 31'(k + 1)});
    k = n_un;
    hw(18'h0, 32'h60);
    hw(18'h00380, 32'hd0);
    chk(mem_addr, 18'h00380);
    wait_ready();
    chk(n_un, k + 1);
    hw(18'h0, 32'h98);
    hr(18'h00040, d);
    chk(seen_sp, 32'h1);
    hw(18'h0, 32'h90);
    hr(18'h00004, d);
    chk(seen_ps, 32'h1);
    hw(18'h0, 32'h70);
    hr(18'h0, d);
    chk(d[7:0], 8'h80);
    t_single();
    t_reset();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
endmodule
